// *** memory_tapped_shift_register.sv ***
// Tapped shift register built from cascaded memory block segments
`timescale 1ns/1ps
`default_nettype none
module memory_tapped_shift_register #(
  parameter int unsigned WIDTH = tapshift_pkg::DEF_WIDTH,
  parameter int unsigned SPACING = tapshift_pkg::DEF_SPACING,
  parameter int unsigned TAPS = tapshift_pkg::DEF_TAPS,
  parameter bit SINGLE_BLOCK = 1'b0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Input word
  input wire logic shift_en_i,
  input wire logic [WIDTH-1:0] din_i,
  // Taps, tap k at bits k*WIDTH-1 downto (k-1)*WIDTH
  output logic [WIDTH*TAPS-1:0] taps_o,
  // Number of memory blocks used
  output logic [15:0] blocks_used_o
);
  localparam int unsigned TOTAL_BITS = WIDTH * SPACING * TAPS;
  localparam int unsigned TAP_BITS = WIDTH * TAPS;
  localparam int unsigned SEG_DEPTH = SPACING - tapshift_pkg::FILL_LAT;
  localparam int unsigned BLK_DEEP = (WIDTH * SPACING + tapshift_pkg::BLOCK_BITS - 1) / tapshift_pkg::BLOCK_BITS;
  localparam int unsigned BLK_WIDE = (TAP_BITS + tapshift_pkg::BLOCK_WIDTH - 1) / tapshift_pkg::BLOCK_WIDTH;
  localparam int unsigned BLK_CAP = (TOTAL_BITS + tapshift_pkg::BLOCK_BITS - 1) / tapshift_pkg::BLOCK_BITS;
  localparam int unsigned BLOCKS = (BLK_CAP > BLK_WIDE) ? BLK_CAP : BLK_WIDE;

  // Configurations beyond one block are refused only in single block mode
  if (WIDTH < 1 || TAPS < 1 || SPACING < 2 || WIDTH > 32) begin : g_bad_cfg
    $error("Unsupported shift register shape");
  end
  if (SINGLE_BLOCK && TOTAL_BITS > tapshift_pkg::BLOCK_BITS) begin : g_bad_bits
    $error("Shift register exceeds one memory block capacity");
  end
  if (SINGLE_BLOCK && TAP_BITS > tapshift_pkg::BLOCK_WIDTH) begin : g_bad_width
    $error("Tap outputs exceed one memory block width");
  end

  tapshift_pkg::shift_in_t in_s;
  logic [WIDTH-1:0] seg_in [TAPS];
  logic [WIDTH-1:0] seg_out [TAPS];

  assign in_s.valid = shift_en_i;
  assign in_s.word = 32'(din_i);

  // Cascade one segment per tap; each adds m accepted words of delay with its output register
  for (genvar k = 0; k < TAPS; k++) begin : g_seg
    if (k == 0) begin : g_first
      assign seg_in[k] = in_s.word[WIDTH-1:0];
    end else begin : g_next
      assign seg_in[k] = seg_out[k-1];
    end
    tapshift_block #(
      .WIDTH(WIDTH),
      .DEPTH(SEG_DEPTH)
    ) u_seg (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .shift_en_i(in_s.valid),
      .din_i(seg_in[k]),
      .dout_o(seg_out[k])
    );
  end

  // Segment depth m-1 plus its read register gives m stages per tap
  assign taps_o = {WIDTH*TAPS{1'b0}} | seg_flat(seg_out);
  assign blocks_used_o = 16'(BLOCKS);

  function automatic logic [WIDTH*TAPS-1:0] seg_flat(input logic [WIDTH-1:0] s [TAPS]);
    logic [WIDTH*TAPS-1:0] r;
    r = '0;
    for (int i = 0; i < TAPS; i++) begin
      r[i*WIDTH +: WIDTH] = s[i];
    end
    return r;
  endfunction

  // Reference delay line for checking: history of accepted words
  logic [WIDTH-1:0] hist_reg [SPACING*TAPS+1];
  logic [15:0] acc_cnt_reg;
  logic [TAPS-1:0] tap_ready;
  logic [WIDTH*TAPS-1:0] held_reg;
  logic held_valid_reg;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      acc_cnt_reg <= '0;
    end else if (shift_en_i) begin
      hist_reg[0] <= din_i;
      for (int i = 1; i <= SPACING*TAPS; i++) begin
        hist_reg[i] <= hist_reg[i-1];
      end
      if (acc_cnt_reg != 16'hffff) begin
        acc_cnt_reg <= acc_cnt_reg + 16'h0001;
      end
    end
  end

  // Helper counter saturates, so longer ages cannot be judged
  if (SPACING * TAPS >= 65535) begin : g_bad_hist
    $error("Shift register too long for the tap age checks");
  end

  // Tap k is judged once more than k*m words have gone in
  for (genvar t = 0; t < TAPS; t++) begin : g_ready
    assign tap_ready[t] = acc_cnt_reg > 16'(SPACING * (t + 1));
  end

  // Snapshot of the taps when a stall begins, kept for its whole length
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      held_valid_reg <= 1'b0;
      held_reg <= '0;
    end else if (shift_en_i) begin
      held_valid_reg <= 1'b0;
    end else begin
      held_valid_reg <= 1'b1;
      if (!held_valid_reg) begin
        held_reg <= taps_o;
      end
    end
  end

  // Steps of a word moving on: a primed accept, then another accept
  sequence seq_primed_accept;
    shift_en_i && tap_ready[0];
  endsequence

  sequence seq_accept;
    shift_en_i;
  endsequence

  sequence seq_stall;
    !shift_en_i;
  endsequence

  chk_tap_one_delay: assert property (@(posedge mclk_i) disable iff (srst_i)
    (acc_cnt_reg > 16'(SPACING)) |-> taps_o[WIDTH-1:0] == hist_reg[SPACING-1])
    else $error("First tap not m words old");

  chk_tap_last_delay: assert property (@(posedge mclk_i) disable iff (srst_i)
    (acc_cnt_reg > 16'(SPACING*TAPS)) |-> taps_o[WIDTH*TAPS-1 -: WIDTH] == hist_reg[SPACING*TAPS-1])
    else $error("Last tap not n*m words old");

  chk_stall_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    seq_stall |=> $stable(taps_o))
    else $error("Taps moved without shift enable");

  chk_one_stage: assert property (@(posedge mclk_i) disable iff (srst_i)
    seq_primed_accept ##1 seq_accept [*1] |->
      taps_o[WIDTH-1:0] == hist_reg[SPACING-1])
    else $error("Data did not advance one stage");

  chk_blocks_fit: assert property (@(posedge mclk_i)
    32'(blocks_used_o) * tapshift_pkg::BLOCK_BITS >= TOTAL_BITS)
    else $error("Block count too small for capacity");

  chk_blocks_deep: assert property (@(posedge mclk_i)
    32'(blocks_used_o) >= BLK_DEEP)
    else $error("Block count too small for one tap length");

  chk_stall_long: assert property (@(posedge mclk_i) disable iff (srst_i)
    held_valid_reg |-> taps_o == held_reg)
    else $error("Taps drifted during a stall");

  chk_reset_clear: assert property (@(posedge mclk_i)
    srst_i |=> taps_o == '0)
    else $error("Taps not cleared by reset");

  // Every tap, middle ones included, against the reference history
  for (genvar t = 1; t <= TAPS; t++) begin : g_tap_chk
    chk_tap_age: assert property (@(posedge mclk_i) disable iff (srst_i)
      tap_ready[t-1] |-> taps_o[t*WIDTH-1 -: WIDTH] == hist_reg[SPACING*t-1])
      else $error("Tap not k times m words old");
  end

  chk_width_fit: assert property (@(posedge mclk_i)
    32'(blocks_used_o) * tapshift_pkg::BLOCK_WIDTH >= TAP_BITS)
    else $error("Block count too small for tap width");
  chk_shape_param: assert property (@(posedge mclk_i)
    $bits(taps_o) == WIDTH * TAPS)
    else $error("Tap bus width mismatch");
  chk_tap_chain: assert property (@(posedge mclk_i) disable iff (srst_i)
    (TAPS > 1 && acc_cnt_reg > 16'(SPACING*TAPS)) |-> seg_out[TAPS-1] == hist_reg[SPACING*TAPS-1])
    else $error("Cascade stage misaligned");
endmodule
`default_nettype wire

// *** tapshift_pkg.sv ***
// Constants and carrier types for the memory tapped shift register
package tapshift_pkg;
  localparam int unsigned BLOCK_BITS = 4608;
  localparam int unsigned BLOCK_WIDTH = 36;
  localparam int unsigned DEF_WIDTH = 8;
  localparam int unsigned DEF_SPACING = 16;
  localparam int unsigned DEF_TAPS = 4;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam int unsigned FILL_LAT = 1;

  typedef struct packed {
    logic valid;
    logic [31:0] word;
  } shift_in_t;
endpackage

// *** tapshift_block.sv ***
// One memory block segment: w-bit ring of depth m-1, read rising, write falling
`timescale 1ns/1ps
`default_nettype none
module tapshift_block #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and control
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic shift_en_i,
  // Data
  input wire logic [WIDTH-1:0] din_i,
  output logic [WIDTH-1:0] dout_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (WIDTH < 1 || DEPTH < 1) begin : g_bad_cfg
    $error("Unsupported segment shape");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] ptr_reg;
  logic [AW-1:0] ptr_next;
  logic [WIDTH-1:0] rd_reg;
  logic [WIDTH-1:0] wdat_reg;
  logic wen_reg;
  logic [AW-1:0] wptr_reg;

  // Pointer wraps modulo depth
  assign ptr_next = (ptr_reg == AW'(DEPTH - 1)) ? '0 : ptr_reg + AW'(1);

  // Rising edge: read oldest word, capture write for the falling edge
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ptr_reg <= tapshift_pkg::PTR_RESET[AW-1:0];
      rd_reg <= '0;
      wen_reg <= 1'b0;
      wdat_reg <= '0;
      wptr_reg <= '0;
    end else begin
      wen_reg <= shift_en_i;
      if (shift_en_i) begin
        rd_reg <= mem_reg[ptr_reg];
        wdat_reg <= din_i;
        wptr_reg <= ptr_reg;
        ptr_reg <= ptr_next;
      end
    end
  end

  // Falling edge: same location written after it was read
  always_ff @(negedge mclk_i) begin
    if (wen_reg) begin
      mem_reg[wptr_reg] <= wdat_reg;
    end
  end

  assign dout_o = rd_reg;
endmodule
`default_nettype wire

// *** tapshift_source.sv ***
// Fabric-side word source feeding the tapped shift register
`timescale 1ns/1ps
`default_nettype none
module tapshift_source #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and control
  input wire logic mclk_i,
  input wire logic run_i,
  // Stream out
  output logic shift_en_o,
  output logic [WIDTH-1:0] din_o
);
  logic [WIDTH-1:0] count_reg = '0;
  logic en_reg = 1'b0;
  logic [WIDTH-1:0] dat_reg = '0;
  // Fresh word per accept, toggling junk while idle
  always @(negedge mclk_i) begin
    en_reg <= run_i;
    if (run_i) begin
      count_reg <= count_reg + 1'b1;
      dat_reg <= count_reg;
    end else begin
      dat_reg <= ~dat_reg;
    end
  end
  assign shift_en_o = en_reg;
  assign din_o = dat_reg;
endmodule
`default_nettype wire

// *** memory_tapped_shift_register_tb_top.sv ***
// Self-checking testbench for the memory tapped shift register
`timescale 1ns/1ps
`default_nettype none
module memory_tapped_shift_register_tb_top;
  // Configuration fits one block: 128 bits, 32 tap bits
  localparam int unsigned W = 8;
  localparam int unsigned M = 4;
  localparam int unsigned N = 4;
  localparam int unsigned BY_BITS = (W*M*N + tapshift_pkg::BLOCK_BITS - 1) / tapshift_pkg::BLOCK_BITS;
  localparam int unsigned BY_WIDTH = (W*N + tapshift_pkg::BLOCK_WIDTH - 1) / tapshift_pkg::BLOCK_WIDTH;
  localparam int unsigned EXP_BLK = BY_BITS > BY_WIDTH ? BY_BITS : BY_WIDTH;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic run = 1'b0;
  logic shift_en;
  logic [W-1:0] din;
  logic [W*N-1:0] taps;
  logic [15:0] blocks;
  logic [W-1:0] hist[$];
  int err_total = 0;
  int checks_done = 0;
  always #2.5 mclk_i = ~mclk_i;
  tapshift_source #(.WIDTH(W)) i_src (.mclk_i(mclk_i), .run_i(run), .shift_en_o(shift_en), .din_o(din));
  memory_tapped_shift_register #(.WIDTH(W), .SPACING(M), .TAPS(N)) i_dut (.mclk_i(mclk_i), .srst_i(srst_i),
    .shift_en_i(shift_en), .din_i(din), .taps_o(taps), .blocks_used_o(blocks));
  // Reference history, newest first
  always @(posedge mclk_i) begin
    if (srst_i) hist.delete();
    else if (shift_en === 1'b1) hist.push_front(din);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_taps();
    for (int k = 1; k <= N; k++) begin
      if (hist.size() >= k*M) check($sformatf("tap%0d", k), 32'(taps[k*W-1 -: W]), 32'(hist[k*M-1]));
    end
  endtask
  task automatic sc_stream(input int n);
    run <= 1'b1;
    repeat (n) begin
      @(negedge mclk_i);
      check_taps();
    end
  endtask
  task automatic sc_stall();
    logic [31:0] held;
    run <= 1'b0;
    repeat (2) @(negedge mclk_i);
    held = taps;
    repeat (6) begin
      @(negedge mclk_i);
      check("taps while idle", taps, held);
    end
  endtask
  task automatic sc_gappy();
    for (int i = 0; i < 24; i++) begin
      run <= i[0];
      @(negedge mclk_i);
      check_taps();
    end
  endtask
  task automatic sc_reset_mid();
    sc_stream(10);
    srst_i <= 1'b1;
    @(negedge mclk_i);
    check("taps after reset", taps, '0);
    srst_i <= 1'b0;
    sc_stream(24);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge mclk_i);
    srst_i <= 1'b0;
    @(negedge mclk_i);
    check("taps after reset", taps, '0);
    check("blocks used", 32'(blocks), 32'(EXP_BLK));
    sc_stream(40);
    sc_stall();
    sc_gappy();
    sc_stall();
    sc_reset_mid();
    test_done();
  end
  // Watchdog
  initial begin
    #10000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
